// file: rtl/dsc_pkg.sv
// shared constants and types for the ddr sdram command interface model
package dsc_pkg;
  localparam int ROW_BITS = 13;
  localparam int COL_BITS_X16 = 9;
  localparam int BANKS = 4;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int AP_BIT = 10;

  // {ras_n, cas_n, we_n} with chip select low
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR = 3'b100,
    CMD_RD = 3'b101,
    CMD_BST = 3'b110,
    CMD_NOP = 3'b111
  } dsc_cmd_e;

  typedef enum logic [1:0] {
    PWR_ON = 2'b00,
    PWR_PRE_PD = 2'b01,
    PWR_ACT_PD = 2'b10,
    PWR_SELF_REF = 2'b11
  } dsc_pwr_e;

  // mode register fields
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  localparam logic [2:0] CL_CODE_25 = 3'h6;
  localparam logic [2:0] CL_CODE_3 = 3'h3;
  localparam logic [3:0] BL_2 = 4'h2;
  localparam logic [3:0] BL_4 = 4'h4;
  localparam logic [3:0] BL_8 = 4'h8;
  // read latency counted in link half cycles
  localparam logic [2:0] LAT_HALF_2 = 3'h4;
  localparam logic [2:0] LAT_HALF_25 = 3'h5;
  localparam logic [2:0] LAT_HALF_3 = 3'h6;
  localparam logic [4:0] PREAMBLE_HALF = 5'h02;
  localparam logic [1:0] MRS_BASE_BANK = 2'h0;
  localparam logic [1:0] MRS_EXT_BANK = 2'h1;
  localparam logic [12:0] MODE_RESET = 13'h0000;

  // apb register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_MODE = 12'h008;
  localparam logic [11:0] REG_REFCNT = 12'h00c;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
endpackage

// file: rtl/dsc_cmd_decode.sv
// command decoder for the registered control pins
`timescale 1ns/1ps
`default_nettype none
module dsc_cmd_decode (
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic enable,
  output var dsc_pkg::dsc_cmd_e cmd,
  output var logic valid
);
  import dsc_pkg::*;

  always_comb
  begin
    valid = !cs_n && enable;
    cmd = dsc_cmd_e'({ras_n, cas_n, we_n}); // [RL18]
  end
endmodule
`default_nettype wire

// file: rtl/dsc_lane_mem.sv
// one byte lane of storage, registered read data
`timescale 1ns/1ps
`default_nettype none
module dsc_lane_mem #(
  parameter int AW = 15,
  parameter int DW = 8
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output var logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge pclk)
  begin
    if (we)
      mem[addr] <= wdata;
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// file: rtl/dsc_ddr_device.sv
// x16 ddr sdram device model: command decode, banks, power states, data bursts
// Operation
// RL1: capture address and control on true clock rising edge, derive timing from clock pair
// RL2: clock enable high runs device; low stops clocks, input buffers and drivers
// RL3: clock enable low: idle banks give precharge power-down/self refresh, open row active
// RL4: power-down entry/exit and self-refresh entry synchronous; self-refresh exit, output off async
// RL5: controller keeps clock enable high through every read and write
// RL6: power-down listens to clock and clock enable only; self refresh clock enable only
// RL7: decode commands only with chip select registered low; ignore all when high
// RL8: write mask sampled on both strobe edges; masked beats leave storage unchanged
// RL9: lower mask and strobe serve bits 0-7, upper ones bits 8-15
// RL10: write mask ignored during reads
// RL11: bank select picks the bank for activate, read, write, single precharge
// RL12: precharge with all-bit high closes every bank, else only selected bank
// RL13: activate takes row address; read/write take column plus auto-precharge bit
// RL14: mode set loads address as opcode; bank select picks base or extended register
// RL15: 13 row bits; x16 column uses A0 to A8
// RL16: read strobe edge-aligned with data; write data captured by controller strobe
// RL17: two data words per clock, launched on rising and falling edges
// RL18: strobe codes: mode LLL, refresh LLH, act LHH, read HLH, write HLL, stop HHL, pre LHL
// RL19: burst lengths 2, 4, 8 with sequential or interleaved ordering
// RL20: read latency 2, 2.5 or 3 clocks
// RL21: controller refreshes every 7.8 us average, at most 8 back to back
// RL22: mode set only with all banks idle, 2 clocks before next command
// RL23: refresh and self-refresh entry only with all banks precharged
// RL24: write mask latency zero: applies to beat on the same strobe edge
// RL25: data and strobe stay released except while driving a read burst
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dsc_ddr_device #(
  parameter int ROW_USED = 4,
  parameter int COL_BITS = dsc_pkg::COL_BITS_X16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic ck,
  input wire logic ck_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_select,
  input wire logic [dsc_pkg::ROW_BITS-1:0] addr,
  input wire logic lower_write_mask,
  input wire logic upper_write_mask,
  input wire logic [15:0] dq_i,
  output var logic [15:0] dq_o,
  output var logic dq_oe,
  input wire logic lower_data_strobe_i,
  output var logic lower_data_strobe_o,
  output var logic lower_data_strobe_oe,
  input wire logic upper_data_strobe_i,
  output var logic upper_data_strobe_o,
  output var logic upper_data_strobe_oe
);
  import dsc_pkg::*;

  localparam int SYNC_W = 42;
  localparam int AW = 2 + ROW_USED + COL_BITS;

  logic [SYNC_W-1:0] in_raw, meta, sync;
  logic ck_s, ck_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, lmask_s, umask_s;
  logic lower_data_strobe_s, upper_data_strobe_s;
  logic [1:0] ba_s;
  logic [ROW_BITS-1:0] addr_s;
  logic [15:0] dq_s;
  logic ck_q, ck_rise, ck_fall, half;
  logic cke_prev, cmd_enable, cmd_valid, cmd_take;
  dsc_cmd_e cmd;
  dsc_pwr_e pwr;
  logic [12:0] mode_reg, ext_mode;
  logic [15:0] ref_cnt;
  logic [3:0] bank_open;
  logic [ROW_BITS-1:0] open_row [BANKS];
  logic [3:0] bl_mode;
  logic [2:0] cl_half;
  logic rd_act, rd_ap, rd_ilv;
  logic [4:0] rd_ph, nph, cl5, bl5, bidx;
  logic [2:0] rd_cl;
  logic [3:0] rd_bl, rd_beat;
  logic [1:0] rd_bank;
  logic [COL_BITS-1:0] rd_col;
  logic beat_now, post_now, end_now, pre_now, rd_close;
  logic wr_act, wr_ap, wr_ilv, wr_close;
  logic [3:0] wr_bl;
  logic [1:0] wr_bank;
  logic [COL_BITS-1:0] wr_col;
  logic [1:0] lane_cap, lane_we, lane_done, mask_lane, dqs_lane;
  logic [3:0] lane_beat [LANES];
  logic lane_started [LANES];
  logic dqs_prev [LANES];
  logic [7:0] lane_rdata [LANES];
  logic dqs_o, dqs_oe;
  logic [AW-1:0] raddr;
  logic [31:0] rd_mux;
  logic reg_hit;

  function automatic logic [COL_BITS-1:0] burst_col(input logic [COL_BITS-1:0] start,
      input logic [2:0] idx, input logic [3:0] bl, input logic ilv);
    logic [COL_BITS-1:0] msk;
    logic [COL_BITS-1:0] low;
    msk = COL_BITS'(bl - 4'h1);
    low = ilv ? (start ^ COL_BITS'(idx)) : (start + COL_BITS'(idx));
    return (start & ~msk) | (low & msk); // [RL19]
  endfunction

  // every pin crosses two flops; all share the delay so they stay aligned with ck
  assign in_raw = {ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
                   lower_write_mask, upper_write_mask, dq_i, lower_data_strobe_i,
                   upper_data_strobe_i};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      sync <= '0;
    end
    else
    begin
      meta <= in_raw;
      sync <= meta;
    end
  end

  assign {ck_s, ck_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s,
          lmask_s, umask_s, dq_s, lower_data_strobe_s, upper_data_strobe_s} = sync;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ck_q <= 1'b0;
    else
      ck_q <= ck_s;
  end

  assign ck_rise = ck_s && !ck_q && !ck_n_s; // [RL1]
  assign ck_fall = !ck_s && ck_q;
  assign half = ck_rise || ck_fall; // [RL17]

  dsc_cmd_decode u_dec (
    .cs_n(cs_n_s),
    .ras_n(ras_n_s),
    .cas_n(cas_n_s),
    .we_n(we_n_s),
    .enable(cmd_enable),
    .cmd(cmd),
    .valid(cmd_valid)
  );

  // only a powered-up device with clock enable held high takes commands
  assign cmd_take = ck_rise && pwr == PWR_ON && cke_prev && cke_s && cmd_valid; // [RL7] [RL6]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cke_prev <= 1'b0;
    else if (ck_rise)
      cke_prev <= cke_s;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr <= PWR_ON;
    else
    begin
      case (pwr)
        PWR_ON:
          if (ck_rise && cke_prev && !cke_s) // [RL4]
          begin
            if (cmd_valid && cmd == CMD_REF)
              pwr <= PWR_SELF_REF; // [RL18]
            else if (|bank_open)
              pwr <= PWR_ACT_PD; // [RL3]
            else
              pwr <= PWR_PRE_PD; // [RL3]
          end
        PWR_PRE_PD, PWR_ACT_PD:
          if (ck_rise && cke_s)
            pwr <= PWR_ON; // [RL4] [RL6]
        PWR_SELF_REF:
          if (cke_s)
            pwr <= PWR_ON; // [RL4] exit needs no clock edge
        default:
          pwr <= PWR_ON;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= MODE_RESET;
      ext_mode <= MODE_RESET;
    end
    else if (cmd_take && cmd == CMD_MRS)
    begin
      if (ba_s == MRS_BASE_BANK)
        mode_reg <= addr_s; // [RL14]
      else if (ba_s == MRS_EXT_BANK)
        ext_mode <= addr_s; // [RL14]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ref_cnt <= 16'h0000;
    else if (cmd_take && cmd == CMD_REF)
      ref_cnt <= ref_cnt + 16'h0001;
  end

  always_comb
  begin
    case (mode_reg[MODE_BL_LSB +: 3])
      BL_CODE_2: bl_mode = BL_2;
      BL_CODE_4: bl_mode = BL_4;
      BL_CODE_8: bl_mode = BL_8;
      default: bl_mode = BL_2;
    endcase
    case (mode_reg[MODE_CL_LSB +: 3])
      CL_CODE_2: cl_half = LAT_HALF_2; // [RL20]
      CL_CODE_25: cl_half = LAT_HALF_25;
      CL_CODE_3: cl_half = LAT_HALF_3;
      default: cl_half = LAT_HALF_25;
    endcase
  end

  genvar b;
  generate
    for (b = 0; b < BANKS; b++)
    begin : g_bank
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          bank_open[b] <= 1'b0;
          open_row[b] <= '0;
        end
        else if (cmd_take && cmd == CMD_ACT && ba_s == 2'(b))
        begin
          bank_open[b] <= 1'b1; // [RL11]
          open_row[b] <= addr_s; // [RL13] [RL15]
        end
        else if ((cmd_take && cmd == CMD_PRE && (addr_s[AP_BIT] || ba_s == 2'(b))) // [RL12]
                 || (rd_close && rd_bank == 2'(b)) || (wr_close && wr_bank == 2'(b)))
          bank_open[b] <= 1'b0;
      end
    end
  endgenerate

  // read burst: phase counts link half cycles from the command edge
  assign nph = rd_ph + 5'h01;
  assign cl5 = 5'(rd_cl);
  assign bl5 = 5'(rd_bl);
  assign bidx = nph - cl5;
  assign end_now = half && rd_act && nph > cl5 + bl5;
  assign post_now = half && rd_act && nph >= cl5 + bl5;
  assign beat_now = half && rd_act && nph >= cl5 && nph < cl5 + bl5;
  assign pre_now = half && rd_act && nph == cl5 - PREAMBLE_HALF;
  assign rd_close = end_now && rd_ap;
  assign raddr = {rd_bank, open_row[rd_bank][ROW_USED-1:0],
                  burst_col(rd_col, rd_beat[2:0], rd_bl, rd_ilv)};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_act <= 1'b0;
      rd_ph <= 5'h00;
      rd_beat <= 4'h0;
      rd_bank <= 2'h0;
      rd_col <= '0;
      rd_ap <= 1'b0;
      rd_cl <= LAT_HALF_25;
      rd_bl <= BL_2;
      rd_ilv <= 1'b0;
    end
    else if (cmd_take && cmd == CMD_RD)
    begin
      rd_act <= 1'b1;
      rd_ph <= 5'h00;
      rd_beat <= 4'h0;
      rd_bank <= ba_s; // [RL11]
      rd_col <= addr_s[COL_BITS-1:0]; // [RL13] [RL15]
      rd_ap <= addr_s[AP_BIT]; // [RL13]
      rd_cl <= cl_half; // [RL20]
      rd_bl <= bl_mode; // [RL19]
      rd_ilv <= mode_reg[MODE_BT_BIT];
    end
    else if (cmd_take && cmd == CMD_BST && rd_act)
      rd_bl <= rd_beat; // truncates after the beats already sent
    else if (half && rd_act)
    begin
      rd_ph <= nph;
      if (beat_now)
        rd_beat <= rd_beat + 4'h1;
      if (end_now)
        rd_act <= 1'b0;
    end
  end

  // pins: released unless a read burst is running; clock enable low drops them at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dq_o <= 16'h0000;
      dq_oe <= 1'b0;
      dqs_o <= 1'b0;
      dqs_oe <= 1'b0;
    end
    else if (!cke_s)
    begin
      dq_oe <= 1'b0; // [RL2] [RL4]
      dqs_oe <= 1'b0;
    end
    else if (!rd_act)
    begin
      dq_oe <= 1'b0; // [RL25]
      dqs_oe <= 1'b0;
    end
    else if (end_now)
    begin
      dqs_oe <= 1'b0;
      dqs_o <= 1'b0;
    end
    else if (post_now)
    begin
      dq_oe <= 1'b0;
      dqs_o <= 1'b0;
    end
    else if (beat_now)
    begin
      dq_oe <= 1'b1; // [RL17]
      dqs_oe <= 1'b1;
      dq_o <= {lane_rdata[1], lane_rdata[0]};
      dqs_o <= !bidx[0]; // [RL16] strobe toggles with each beat
    end
    else if (pre_now)
    begin
      dqs_oe <= 1'b1;
      dqs_o <= 1'b0;
    end
  end

  assign lower_data_strobe_o = dqs_o;
  assign lower_data_strobe_oe = dqs_oe;
  assign upper_data_strobe_o = dqs_o;
  assign upper_data_strobe_oe = dqs_oe;

  // write burst: each lane counts beats on its own strobe
  assign mask_lane = {umask_s, lmask_s};
  assign dqs_lane = {upper_data_strobe_s, lower_data_strobe_s};
  assign wr_close = wr_act && (&lane_done) && wr_ap;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_act <= 1'b0;
      wr_bank <= 2'h0;
      wr_col <= '0;
      wr_ap <= 1'b0;
      wr_bl <= BL_2;
      wr_ilv <= 1'b0;
    end
    else if (cmd_take && cmd == CMD_WR)
    begin
      wr_act <= 1'b1;
      wr_bank <= ba_s; // [RL11]
      wr_col <= addr_s[COL_BITS-1:0]; // [RL13]
      wr_ap <= addr_s[AP_BIT];
      wr_bl <= bl_mode;
      wr_ilv <= mode_reg[MODE_BT_BIT];
    end
    else if (wr_act && (&lane_done))
      wr_act <= 1'b0;
  end

  genvar l;
  generate
    for (l = 0; l < LANES; l++)
    begin : g_lane
      logic [AW-1:0] waddr;
      logic edge_ok;
      // a floating strobe before the preamble must not count: first beat needs a rise
      assign edge_ok = (dqs_lane[l] && !dqs_prev[l])
                       || (!dqs_lane[l] && dqs_prev[l] && lane_started[l]);
      assign lane_cap[l] = wr_act && lane_beat[l] < wr_bl && edge_ok; // [RL16] [RL9]
      assign lane_we[l] = lane_cap[l] && !mask_lane[l]; // [RL8] [RL24] [RL10]
      assign lane_done[l] = lane_beat[l] == wr_bl;
      assign waddr = {wr_bank, open_row[wr_bank][ROW_USED-1:0],
                      burst_col(wr_col, lane_beat[l][2:0], wr_bl, wr_ilv)};

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          lane_beat[l] <= 4'h0;
          lane_started[l] <= 1'b0;
          dqs_prev[l] <= 1'b0;
        end
        else
        begin
          dqs_prev[l] <= dqs_lane[l];
          if (cmd_take && cmd == CMD_WR)
          begin
            lane_beat[l] <= 4'h0;
            lane_started[l] <= 1'b0;
          end
          else if (lane_cap[l])
          begin
            lane_beat[l] <= lane_beat[l] + 4'h1; // [RL8] masked beats still advance
            lane_started[l] <= 1'b1;
          end
        end
      end

      dsc_lane_mem #(.AW(AW), .DW(LANE_W)) u_mem (
        .pclk(pclk),
        .we(lane_we[l]),
        .addr(lane_we[l] ? waddr : raddr),
        .wdata(dq_s[LANE_W*l +: LANE_W]),
        .rdata(lane_rdata[l])
      );
    end
  endgenerate

  // apb slave: one wait state, error on unmapped offsets
  always_comb
  begin
    reg_hit = 1'b1;
    case (paddr)
      REG_CTRL: rd_mux = {31'h0, cmd_enable};
      REG_STATUS: rd_mux = {24'h0, wr_act, rd_act, bank_open, pwr};
      REG_MODE: rd_mux = {3'h0, ext_mode, 3'h0, mode_reg};
      REG_REFCNT: rd_mux = {16'h0, ref_cnt};
      default:
      begin
        rd_mux = 32'h0;
        reg_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      pslverr <= !reg_hit;
      prdata <= pwrite ? 32'h0 : rd_mux;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_enable <= CTRL_EN_RESET;
    else if (psel && penable && pready && pwrite && paddr == REG_CTRL)
      cmd_enable <= pwdata[CTRL_EN_BIT];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  cmd_gate_a: assert property ( // [RL7]
    ck_rise && cs_n_s && !rd_act && !wr_act |=> $stable(bank_open) && $stable(mode_reg))
    else $error("state changed with chip select high");
  act_open_a: assert property ( // [RL13]
    cmd_take && cmd == CMD_ACT |=> bank_open[$past(ba_s)] && open_row[$past(ba_s)] == $past(addr_s))
    else $error("activate did not open the row");
  pre_all_a: assert property ( // [RL12]
    cmd_take && cmd == CMD_PRE && addr_s[AP_BIT] |=> bank_open == 4'h0)
    else $error("precharge all left a bank open");
  ppd_entry_a: assert property ( // [RL3]
    pwr == PWR_ON && ck_rise && cke_prev && !cke_s && !(cmd_valid && cmd == CMD_REF)
    && bank_open == 4'h0 |=> pwr == PWR_PRE_PD)
    else $error("precharge power-down not entered");
  apd_entry_a: assert property ( // [RL3]
    pwr == PWR_ON && ck_rise && cke_prev && !cke_s && !(cmd_valid && cmd == CMD_REF)
    && bank_open != 4'h0 |=> pwr == PWR_ACT_PD)
    else $error("active power-down not entered");
  sref_exit_a: assert property ( // [RL4]
    pwr == PWR_SELF_REF && cke_s |=> pwr == PWR_ON)
    else $error("self refresh exit missed");
  out_off_a: assert property ( // [RL2]
    !cke_s |=> !dq_oe && !dqs_oe)
    else $error("drivers on with clock enable low");
  ext_load_a: assert property ( // [RL14]
    cmd_take && cmd == CMD_MRS && ba_s == MRS_EXT_BANK |=> ext_mode == $past(addr_s))
    else $error("extended mode register not loaded");
  read_pre_a: assert property ( // [RL16]
    $rose(dq_oe) |-> $past(dqs_oe) && !$past(dqs_o) && dqs_o)
    else $error("read beat without preamble");

  read_cov_c: cover property (beat_now && rd_beat == 4'h3);
  write_cov_c: cover property (lane_we[0] && lane_we[1]);
  mask_cov_c: cover property (lane_cap[1] && !lane_we[1]);
  sref_cov_c: cover property (pwr == PWR_ON ##1 pwr == PWR_SELF_REF);
endmodule
`default_nettype wire

// file: dv/dsc_ctrl_model.sv
// controller-side model: link clock, command pins and write bursts
`timescale 1ns/1ps
`default_nettype none
module dsc_ctrl_model (
  output var logic ck,
  output logic ck_n,
  output var logic cke,
  output var logic cs_n,
  output var logic ras_n,
  output var logic cas_n,
  output var logic we_n,
  output var logic [1:0] bank_select,
  output var logic [12:0] addr,
  output var logic lower_write_mask,
  output var logic upper_write_mask,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  output logic [15:0] dq_i,
  input wire logic lower_data_strobe_o,
  input wire logic lower_data_strobe_oe,
  output logic lower_data_strobe_i,
  input wire logic upper_data_strobe_o,
  input wire logic upper_data_strobe_oe,
  output logic upper_data_strobe_i
);
  logic [15:0] dq_drv;
  logic dq_en;
  logic s_val;
  logic s_en;
  // released lines show the inverse of their last level so stale values never pass
  assign dq_i = dq_oe ? dq_o : (dq_en ? dq_drv : ~dq_drv);
  assign lower_data_strobe_i = lower_data_strobe_oe ? lower_data_strobe_o : s_val ^ !s_en;
  assign upper_data_strobe_i = upper_data_strobe_oe ? upper_data_strobe_o : s_val ^ !s_en;
  assign ck_n = ~ck;
  initial
  begin
    {cke, cs_n, ras_n, cas_n, we_n, lower_write_mask, upper_write_mask} = 7'h7c;
    {bank_select, addr, dq_drv, dq_en, s_val, s_en} = '0;
    ck = 1'b0;
    #3;
    forever #40 ck = ~ck;
  end
  // pins move on the falling edge so they are settled at the rising one
  task automatic cmd(input logic k, input logic [3:0] c, input logic [1:0] b,
                     input logic [12:0] a);
    begin
      @(negedge ck);
      cke <= k;
      {cs_n, ras_n, cas_n, we_n} <= c;
      bank_select <= b;
      addr <= a;
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n} <= 4'b0111;
      @(negedge ck); // two clocks before the next command
    end
  endtask
  task automatic wr(input logic [1:0] b, input logic [12:0] c, input logic [63:0] d,
                    input logic [7:0] m);
    begin
      cmd(1'b1, 4'b0100, b, c); // clock enable stays high through the burst
      s_en <= 1'b1;
      s_val <= 1'b0;
      dq_en <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
        dq_drv <= d[16*i +: 16];
        {upper_write_mask, lower_write_mask} <= m[2*i +: 2];
        #20 s_val <= ~s_val; // strobe edge centred in the beat
        #20;
      end
      #20 s_en <= 1'b0;
      dq_en <= 1'b0;
    end
  endtask
  task automatic rd(input logic [1:0] b, input logic [12:0] c);
    begin
      {upper_write_mask, lower_write_mask} <= 2'b11; // masks held high must not matter
      cmd(1'b1, 4'b0101, b, c);
      repeat (4) @(negedge ck);
    end
  endtask
endmodule
`default_nettype wire

// file: dv/dsc_ddr_device_test.sv
// self-checking bench for the ddr device model: apb registers and link traffic
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module dsc_ddr_device_test;
  import dsc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, lower_write_mask, upper_write_mask, dq_oe;
  logic [1:0] bank_select;
  logic [12:0] addr;
  logic [15:0] dq_i, dq_o;
  logic lower_data_strobe_i, lower_data_strobe_o, lower_data_strobe_oe;
  logic upper_data_strobe_i, upper_data_strobe_o, upper_data_strobe_oe;
  logic oe_q, s_q;
  logic [63:0] d, ex;
  logic [7:0] m;
  logic [32:0] aq[$];
  logic [17:0] dq_q[$];
  logic [32:0] exp_a;
  logic [17:0] exp_d;
  int num_errors = 0;
  int cmp_count = 0;
  dsc_ddr_device dut_u (.*);
  dsc_ctrl_model ctrl_u (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
    end
  endfunction
  task automatic summarize();
    begin
      if (num_errors == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [32:0] e);
    int n;
    begin
      if (!w)
        aq.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (!pready && n < 50);
      if (!pready)
      begin
        num_errors++;
        summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  always @(posedge pclk)
  begin
    // pop once: the macro names its expected value twice
    if (psel && penable && pready && !pwrite)
    begin
      exp_a = aq.size() ? aq.pop_front() : 'x;
      `CHK({pslverr, prdata}, exp_a)
    end
    if (dq_oe && (!oe_q || lower_data_strobe_o !== s_q))
    begin
      exp_d = dq_q.size() ? dq_q.pop_front() : 'x;
      `CHK({upper_data_strobe_o, lower_data_strobe_o, dq_o}, exp_d)
    end
    oe_q <= dq_oe;
    s_q <= lower_data_strobe_o;
  end
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 32'hdf699ce3;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, REG_CTRL, 0, {32'h0, CTRL_EN_RESET});
    apb(0, REG_STATUS, 0, 33'h0);
    apb(0, 12'h010, 0, {1'b1, 32'h0}); // unmapped offset answers with an error
    #400;
    seed = xs(seed);
    ctrl_u.cmd(1, 4'b0000, MRS_BASE_BANK, {6'h0, CL_CODE_2, 1'b0, BL_CODE_4});
    ctrl_u.cmd(1, 4'b0000, MRS_EXT_BANK, seed[12:0]);
    apb(0, REG_MODE, 0, {4'h0, seed[12:0], 9'h0, CL_CODE_2, 1'b0, BL_CODE_4});
    apb(1, REG_CTRL, 0, 0);
    ctrl_u.cmd(1, 4'b0011, 2'h3, 13'h0002); // ignored while disabled
    apb(1, REG_CTRL, 1, 0);
    ctrl_u.cmd(1, 4'b0011, 2'h2, 13'h0003);
    ctrl_u.cmd(1, 4'b0011, 2'h0, 13'h0001);
    ctrl_u.cmd(1, 4'b1011, 2'h1, 13'h0001); // deselected activate
    apb(0, REG_STATUS, 0, 33'h14);
    ctrl_u.cmd(1, 4'b0010, 2'h0, 13'h0000); // single-bank precharge
    apb(0, REG_STATUS, 0, 33'h10);
    for (int k = 0; k < 2; k++)
    begin
      m = k ? 8'h06 : 8'h00;
      seed = xs(seed);
      d[31:0] = seed;
      seed = xs(seed);
      d[63:32] = seed;
      for (int j = 0; j < 8; j++)
        if (!m[j])
          ex[8*j +: 8] = d[8*j +: 8]; // masked bytes keep old data
      ctrl_u.wr(2'h2, 13'h0004, d, m);
    end
    for (int i = 0; i < 4; i++)
      dq_q.push_back({{2{~i[0]}}, ex[16*i +: 16]});
    ctrl_u.rd(2'h2, 13'h0004);
    ctrl_u.cmd(0, 4'b0111, 2'h0, 13'h0000); // row open: active power-down
    apb(0, REG_STATUS, 0, {31'h0, PWR_ACT_PD} | 33'h10);
    ctrl_u.cmd(1, 4'b0111, 2'h0, 13'h0000);
    ctrl_u.cmd(1, 4'b0010, 2'h1, 13'h0400); // precharge all ignores bank
    ctrl_u.cmd(1, 4'b0001, 2'h0, 13'h0000); // refresh with banks idle
    apb(0, REG_REFCNT, 0, 33'h1);
    ctrl_u.cmd(0, 4'b0111, 2'h0, 13'h0000);
    apb(0, REG_STATUS, 0, {31'h0, PWR_PRE_PD});
    ctrl_u.cmd(1, 4'b0111, 2'h0, 13'h0000);
    ctrl_u.cmd(0, 4'b0001, 2'h0, 13'h0000); // refresh code with enable falling
    apb(0, REG_STATUS, 0, {31'h0, PWR_SELF_REF});
    apb(0, REG_REFCNT, 0, 33'h1);
    ctrl_u.cmd(1, 4'b0111, 2'h0, 13'h0000);
    apb(0, REG_STATUS, 0, 33'h0);
    ctrl_u.cmd(1, 4'b0000, MRS_BASE_BANK, {6'h0, CL_CODE_25, 1'b1, BL_CODE_4});
    ctrl_u.cmd(1, 4'b0011, 2'h2, 13'h0003);
    for (int i = 0; i < 4; i++)
      dq_q.push_back({{2{~i[0]}}, ex[16*(i^1) +: 16]}); // interleaved from column 5
    ctrl_u.rd(2'h2, 13'h0405); // auto-precharge closes the bank
    apb(0, REG_STATUS, 0, 33'h0);
    for (int n = 0; n < 100 && aq.size() + dq_q.size() > 0; n++)
      @(posedge pclk);
    if (aq.size() + dq_q.size() > 0)
      num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
